// ### lcdc_ctrl.v
// Purpose: Segment LCD control register bank with clock and pump dividers
// Assumes: Sub-clock edges arrive as a synchronous one-cycle tick input
// Notes:   AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/10ps
`include "lcdc_regs.vh"

module lcdc_ctrl #(
  parameter CNT_W = `LCDC_CNT_W
) (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  input  wire        hsel_in,
  input  wire [11:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  input  wire        rc_tick_in,
  input  wire        xtal_tick_in,
  input  wire        subclock_source_select_in,
  input  wire        sleep_in,
  output reg         lcd_clk_en_out,
  output reg         pump_clk_en_out,
  output reg         lcd_reset_out,
  output reg         display_on_out,
  output reg         wave_type_b_out,
  output reg         bias_kind_cap_out,
  output reg  [1:0]  cap_bias_power_source_out,
  output reg  [3:0]  res_bias_current_onehot_out,
  output reg         res_bias_path_on_out,
  output reg         res_pump_on_out,
  output reg  [1:0]  pump_level_select_out,
  output reg         cap_pump_on_out,
  output reg  [2:0]  pump_clock_divider_out,
  output reg  [1:0]  duty_select_out,
  output reg  [7:0]  com_used_out,
  output reg         bias_quarter_out
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg  [7:0]       main_q;
  reg  [7:0]       pump_q;
  reg  [7:0]       duty_q;
  reg              wr_pend_q;
  reg  [11:0]      wr_addr_q;
  reg  [CNT_W-1:0] div_cnt_q;
  wire [CNT_W-1:0] div_cnt_d;
  wire             sub_tick;
  wire             addr_ok;
  wire             lcd_active;
  wire             kind_cap;
  reg  [7:0]       rd_mux;
  reg  [CNT_W-1:0] pck_mask;
  reg  [7:0]       com_mask;

  // Address phase accepted only for valid transfers
  assign addr_ok = hsel_in & hready_in & htrans_in[1];

  // ----------------------------------------
  // Bus write capture and register update
  // ----------------------------------------
  // Write data arrives one cycle after the address phase
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      main_q    <= `LCDC_RST_VAL;
      pump_q    <= `LCDC_RST_VAL;
      duty_q    <= `LCDC_RST_VAL;
    end else begin
      wr_pend_q <= addr_ok & hwrite_in;
      if (addr_ok)
        wr_addr_q <= haddr_in;
      if (wr_pend_q) begin
        // Unimplemented bits never store, so they read zero
        case (wr_addr_q)
          `LCDC_MAIN_OFS: main_q <= hwdata_in[7:0] & `LCDC_MAIN_MASK;
          `LCDC_PUMP_OFS: pump_q <= hwdata_in[7:0] & `LCDC_PUMP_MASK;
          `LCDC_DUTY_OFS: duty_q <= hwdata_in[7:0] & `LCDC_DUTY_MASK;
          default: ;
        endcase
      end
    end
  end

  // Read mux; status word reports the registered display, resistor pump and capacitor pump on states
  always @* begin
    case (haddr_in)
      `LCDC_MAIN_OFS: rd_mux = main_q;
      `LCDC_PUMP_OFS: rd_mux = pump_q;
      `LCDC_DUTY_OFS: rd_mux = duty_q;
      `LCDC_STAT_OFS: rd_mux = {5'h00, cap_pump_on_out, res_pump_on_out, display_on_out};
      default:        rd_mux = 8'h00;
    endcase
    // Forward a write still in its data phase, else a back-to-back read is stale
    if (wr_pend_q && (wr_addr_q == haddr_in)) begin
      case (wr_addr_q)
        `LCDC_MAIN_OFS: rd_mux = hwdata_in[7:0] & `LCDC_MAIN_MASK;
        `LCDC_PUMP_OFS: rd_mux = hwdata_in[7:0] & `LCDC_PUMP_MASK;
        `LCDC_DUTY_OFS: rd_mux = hwdata_in[7:0] & `LCDC_DUTY_MASK;
        default:        rd_mux = rd_mux;
      endcase
    end
  end

  // Read data registered at the end of address phase, zero wait states
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (addr_ok & ~hwrite_in)
        hrdata_out <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------
  // Sub-clock source and shared divider
  // ----------------------------------------
  // Slow oscillator choice
  assign sub_tick = subclock_source_select_in ? xtal_tick_in : rc_tick_in;

  // One free-running counter keeps every derived rate in phase
  assign div_cnt_d = div_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      div_cnt_q <= {CNT_W{1'b0}};
    else if (sub_tick)
      div_cnt_q <= div_cnt_d;
  end

  // Pump divide mask: code n divides by 2^(7-n), 111 same as 110
  always @* begin
    case (duty_q[`LCDC_PCK_HI:`LCDC_PCK_LO])
      3'h0:    pck_mask = 7'h7F;
      3'h1:    pck_mask = 7'h3F;
      3'h2:    pck_mask = 7'h1F;
      3'h3:    pck_mask = 7'h0F;
      3'h4:    pck_mask = 7'h07;
      3'h5:    pck_mask = 7'h03;
      default: pck_mask = 7'h01;
    endcase
  end

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  assign lcd_active = main_q[`LCDC_EN_BIT] & ~sleep_in;
  assign kind_cap   = main_q[`LCDC_KIND_BIT];

  // Commons left free by the duty go back to shared pins
  always @* begin
    case (duty_q[`LCDC_DUTY_HI:`LCDC_DUTY_LO])
      2'h0:    com_mask = 8'h0F;
      2'h1:    com_mask = 8'h3F;
      2'h2:    com_mask = 8'hFF;
      default: com_mask = 8'h0F; // Undefined code, fall back to four
    endcase
  end

  // All outputs registered; clock enables are one-cycle pulses
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lcd_clk_en_out              <= 1'b0;
      pump_clk_en_out             <= 1'b0;
      lcd_reset_out               <= 1'b1;
      display_on_out              <= 1'b0;
      wave_type_b_out             <= 1'b0;
      bias_kind_cap_out           <= 1'b0;
      cap_bias_power_source_out   <= 2'h0;
      res_bias_current_onehot_out <= 4'h0;
      res_bias_path_on_out        <= 1'b0;
      res_pump_on_out             <= 1'b0;
      pump_level_select_out       <= 2'h0;
      cap_pump_on_out             <= 1'b0;
      pump_clock_divider_out      <= 3'h0;
      duty_select_out             <= 2'h0;
      com_used_out                <= 8'h00;
      bias_quarter_out            <= 1'b0;
    end else begin
      // Divide by eight on the shared counter
      lcd_clk_en_out  <= sub_tick & (div_cnt_q[`LCDC_LCD_DIV_LOG2-1:0] == 3'h7);
      pump_clk_en_out <= sub_tick & cap_pump_on_out
                         & ((div_cnt_q & pck_mask) == pck_mask);
      // Reset while disabled or asleep; drivers hold low
      lcd_reset_out   <= ~lcd_active;
      display_on_out  <= lcd_active;
      wave_type_b_out   <= main_q[`LCDC_WAVE_BIT];
      bias_kind_cap_out <= kind_cap;
      cap_bias_power_source_out <= main_q[`LCDC_PSRC_HI:`LCDC_PSRC_LO];
      // One-hot current select: 25/50/100/200 uA
      res_bias_current_onehot_out <= 4'h1 << main_q[`LCDC_ICUR_HI:`LCDC_ICUR_LO];
      // DC path only draws while running with resistor bias
      res_bias_path_on_out <= lcd_active & ~kind_cap;
      // Pump off on external supply, cap bias or disable
      res_pump_on_out <= pump_q[`LCDC_RSUP_BIT] & ~kind_cap & main_q[`LCDC_EN_BIT]
                         & ~sleep_in;
      pump_level_select_out  <= pump_q[`LCDC_LVL_HI:`LCDC_LVL_LO];
      cap_pump_on_out        <= kind_cap & lcd_active;
      pump_clock_divider_out <= duty_q[`LCDC_PCK_HI:`LCDC_PCK_LO];
      duty_select_out        <= duty_q[`LCDC_DUTY_HI:`LCDC_DUTY_LO];
      com_used_out           <= lcd_active ? com_mask : 8'h00;
      bias_quarter_out       <= duty_q[`LCDC_BIAS_BIT];
    end
  end

endmodule // lcdc_ctrl

// ### lcdc_ctrl_properties.sv
// Purpose: Port-level assertions for the LCD control bank
// Assumes: Derived outputs share one register stage
// Notes:   Bound to every lcdc_ctrl instance
`timescale 1ns/10ps
module lcdc_ctrl_props (
  input logic       ref_clk_in,
  input logic       rst_n_in,
  input logic       sleep_in,
  input logic       hreadyout_out,
  input logic       hresp_out,
  input logic       lcd_clk_en_out,
  input logic       lcd_reset_out,
  input logic       display_on_out,
  input logic       bias_kind_cap_out,
  input logic [3:0] res_bias_current_onehot_out,
  input logic       res_bias_path_on_out,
  input logic       res_pump_on_out,
  input logic       cap_pump_on_out,
  input logic [1:0] duty_select_out,
  input logic [7:0] com_used_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Seven idle cycles at least between LCD clock pulses
  sequence s_quiet7;
    !lcd_clk_en_out [*7];
  endsequence
  AST_LCD_DIV: assert property (lcd_clk_en_out |=> s_quiet7)
    else $error("LCD clock pulse too early");
  AST_SLEEP_OFF: assert property (sleep_in |=> !display_on_out)
    else $error("display on during sleep");
  AST_RESET_PAIR: assert property (lcd_reset_out == !display_on_out)
    else $error("LCD reset disagrees with display state");
  AST_RES_PUMP: assert property (res_pump_on_out |-> display_on_out && !bias_kind_cap_out)
    else $error("resistor pump on while it must be off");
  AST_CAP_PUMP: assert property (cap_pump_on_out == (display_on_out && bias_kind_cap_out))
    else $error("capacitor pump state wrong");
  AST_DC_PATH: assert property (res_bias_path_on_out == (display_on_out && !bias_kind_cap_out))
    else $error("bias DC path state wrong");
  AST_CUR_ONEHOT: assert property (display_on_out |-> $onehot(res_bias_current_onehot_out))
    else $error("bias current select not one-hot");
  AST_COM_USED: assert property (com_used_out == (!display_on_out ? 8'h00 :
    duty_select_out == 2'h1 ? 8'h3F : duty_select_out == 2'h2 ? 8'hFF : 8'h0F))
    else $error("common pin usage wrong");
  AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave not ready or not OKAY");
endmodule // lcdc_ctrl_props

bind lcdc_ctrl lcdc_ctrl_props u_props (.*);

// ### lcdc_ctrl_tb.sv
// Purpose: Self-checking bench for the LCD control register bank
// Assumes: Zero-wait AHB-Lite slave; sub-clock ticks driven here
// Notes:   Register, gating, field and divider tests
`timescale 1ns/10ps
`include "lcdc_regs.vh"
module lcdc_ctrl_tb;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic rc_tick_in = 1'b1, xtal_tick_in = 1'b0, subclock_source_select_in = 1'b0;
  logic sleep_in = 1'b0;
  logic [11:0] haddr_in = 12'h000;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0000_0000, rd;
  wire hready_in, hreadyout_out, hresp_out, lcd_clk_en_out, pump_clk_en_out;
  wire lcd_reset_out, display_on_out, wave_type_b_out, bias_kind_cap_out;
  wire res_bias_path_on_out, res_pump_on_out, cap_pump_on_out, bias_quarter_out;
  wire [31:0] hrdata_out;
  wire [1:0]  cap_bias_power_source_out, pump_level_select_out, duty_select_out;
  wire [3:0]  res_bias_current_onehot_out;
  wire [2:0]  pump_clock_divider_out;
  wire [7:0]  com_used_out;
  int error_cnt = 0, num_checks = 0, i, n, a, b;
  logic [7:0] m [3] = '{8'hF7, 8'h0B, 8'hE7};
  // Fill patterns that keep the software bias rules
  logic [7:0] w [3] = '{8'hF9, 8'hFF, 8'hFE};
  // One slave, so its ready is the bus ready
  assign hready_in = hreadyout_out;
  lcdc_ctrl DUT (.*);
  initial forever #10 ref_clk_in = ~ref_clk_in;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Single AHB transfer; read data taken at the data-phase edge
  task automatic acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
    hsel_in <= 1'b1; htrans_in <= 2'h2; hwrite_in <= w; haddr_in <= ad;
    @(posedge ref_clk_in);
    while (hready_in !== 1'b1) @(posedge ref_clk_in);
    hsel_in <= 1'b0; htrans_in <= 2'h0; hwdata_in <= d;
    @(posedge ref_clk_in);
    while (hready_in !== 1'b1) @(posedge ref_clk_in);
    rd = hrdata_out;
  endtask
  task automatic count64(output int cl, cp);
    cl = 0; cp = 0;
    repeat (64) begin
      @(posedge ref_clk_in);
      #1;
      cl += lcd_clk_en_out; cp += pump_clk_en_out;
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 400 cycles
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    chk("lcd_reset", lcd_reset_out, 1);
    for (i = 0; i < 3; i++) begin
      acc(1'b0, 12'(i * 4), 0); chk("reset value", rd, 0);
      acc(1'b1, 12'(i * 4), {24'hFF_FFFF, w[i]});
      acc(1'b0, 12'(i * 4), 0); chk("write mask", rd, {24'h0, w[i] & m[i]});
    end
    acc(1'b1, 12'h010, 32'hFFFF_FFFF);
    acc(1'b0, 12'h010, 0); chk("unmapped", rd, 0);
    $display("test registers done");
    // Enable, bias kind and sleep in every combination
    acc(1'b1, `LCDC_PUMP_OFS, 32'h0000_0008);
    for (i = 0; i < 8; i++) begin
      sleep_in <= i[2];
      acc(1'b1, `LCDC_MAIN_OFS, {25'h0, i[1], 5'h0, i[0]});
      repeat (2) @(posedge ref_clk_in);
      n = i[0] & !i[2];
      chk("display_on", display_on_out, n);
      chk("lcd_reset", lcd_reset_out, !n);
      chk("res_pump", res_pump_on_out, n & !i[1]);
      chk("cap_pump", cap_pump_on_out, n & i[1]);
      chk("bias_path", res_bias_path_on_out, n & !i[1]);
      acc(1'b0, `LCDC_STAT_OFS, 0);
      chk("status", rd, {29'h0, 1'(n & i[1]), 1'(n & !i[1]), 1'(n)});
    end
    sleep_in <= 1'b0;
    acc(1'b1, `LCDC_PUMP_OFS, 0);
    acc(1'b1, `LCDC_MAIN_OFS, 1);
    repeat (2) @(posedge ref_clk_in);
    chk("res_pump pin", res_pump_on_out, 0);
    $display("test gating done");
    // Every code of every field except the pump divider, of which codes 000, 011, 100 and 111
    for (i = 0; i < 4; i++) begin
      // Power source only under capacitor bias, current field held at 00
      acc(1'b1, `LCDC_DUTY_OFS, 0);
      acc(1'b1, `LCDC_MAIN_OFS, {24'h0, i[0], 1'b1, i[1:0], 4'h1});
      repeat (2) @(posedge ref_clk_in);
      chk("power source", cap_bias_power_source_out, i[1:0]);
      // Bias current only under resistor bias, power source held at 00
      acc(1'b1, `LCDC_MAIN_OFS, {24'h0, i[0], 4'h0, i[1:0], 1'b1});
      acc(1'b1, `LCDC_PUMP_OFS, {28'h0, i[0], 1'b0, i[1:0]});
      acc(1'b1, `LCDC_DUTY_OFS, {24'h0, i[1:0], i[0], 2'h0, i[1:0], i[0]});
      repeat (2) @(posedge ref_clk_in);
      chk("wave", wave_type_b_out, i[0]);
      chk("bias current", res_bias_current_onehot_out, 4'h1 << i);
      chk("pump level", pump_level_select_out, i[1:0]);
      chk("pump divider", pump_clock_divider_out, {i[1:0], i[0]});
      chk("duty", duty_select_out, i[1:0]);
      chk("com used", com_used_out, i == 1 ? 8'h3F : i == 2 ? 8'hFF : 8'h0F);
      chk("bias quarter", bias_quarter_out, i[0]);
    end
    $display("test fields done");
    count64(a, b);
    chk("lcd clk rc", a, 8);
    chk("pump clk off", b, 0);
    subclock_source_select_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    count64(a, b); chk("lcd clk idle xtal", a, 0);
    xtal_tick_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    count64(a, b); chk("lcd clk xtal", a, 8);
    acc(1'b1, `LCDC_MAIN_OFS, 32'h0000_0041);
    acc(1'b1, `LCDC_DUTY_OFS, 32'h0000_00C0);
    repeat (2) @(posedge ref_clk_in);
    count64(a, b); chk("pump clk half", b, 32);
    $display("test clocks done");
    print_verdict;
  end
endmodule // lcdc_ctrl_tb

// ### lcdc_regs.vh
// Purpose: Constants for the segment LCD control register bank
// Assumes: 8-bit registers, each in one aligned 32-bit AHB word
// Notes:   Offsets are byte addresses
//
// Function
// - LCD clock is the sub-clock divided by eight, nominally 4kHz.
// - Sub-clock comes from slow RC or slow crystal, chosen by a select bit.
// - Enable bit 0 turns display on; sleep forces it off.
// - Main bit 7 selects waveform Type A (0) or Type B (1).
// - Main bit 6 selects resistor (0) or capacitor (1) bias.
// - Power source field bits 5..4 pick external, reference, middle or top node.
// - Bias current field bits 2..1 picks 25, 50, 100 or 200 uA.
// - Unimplemented bits read as zero in all three registers.
// - Pump bit 3 selects external pin or internal pump for resistor bias.
// - Resistor pump off if select is 0, capacitor bias, or display disabled.
// - Pump level field bits 1..0 picks 3.3, 3.0, 2.7 or 4.5 V.
// - Pump clock field divides sub-clock by 128 down to 2; code 111 also 2.
// - Duty field picks four, six or eight commons; code 11 undefined.
// - Commons unused by the duty stay free for general-purpose pins.
// - Duty bit 0 selects one-third or one-quarter bias.
// - Capacitor bias enables the capacitor pump at the chosen clock rate.
// - Resistor bias current path is off when the LCD is disabled.
// - LCD held in reset when disabled or sleeping; outputs driven low.
`ifndef LCDC_REGS_VH
`define LCDC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LCDC_MAIN_OFS      12'h000
`define LCDC_PUMP_OFS      12'h004
`define LCDC_DUTY_OFS      12'h008
`define LCDC_STAT_OFS      12'h00C

// ----------------------------------------
// Write masks of implemented bits and reset values
// ----------------------------------------
`define LCDC_MAIN_MASK     8'hF7
`define LCDC_PUMP_MASK     8'h0B
`define LCDC_DUTY_MASK     8'hE7
`define LCDC_RST_VAL       8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCDC_EN_BIT        0
`define LCDC_WAVE_BIT      7
`define LCDC_KIND_BIT      6
`define LCDC_PSRC_HI       5
`define LCDC_PSRC_LO       4
`define LCDC_ICUR_HI       2
`define LCDC_ICUR_LO       1
`define LCDC_RSUP_BIT      3
`define LCDC_LVL_HI        1
`define LCDC_LVL_LO        0
`define LCDC_PCK_HI        7
`define LCDC_PCK_LO        5
`define LCDC_DUTY_HI       2
`define LCDC_DUTY_LO       1
`define LCDC_BIAS_BIT      0

// ----------------------------------------
// Timing: sub-clock divide counter
// ----------------------------------------
`define LCDC_LCD_DIV_LOG2  3
`define LCDC_CNT_W         7

`endif
